// File: tb/hcoc_host_model.sv
// Purpose: Bus master model that opens, reads and writes register frames
// Assumes: SDA resolved outside as wired-AND with a pull-up
// Notes:   SCL stands high between frames; bit period 32 ns
`timescale 1ns/1ns
`default_nettype none
module hcoc_host_model (
    output var  logic scl_o,
    output var  logic sda_low_o,
    input  wire logic sda_i
);
    initial begin
        scl_o     = 1'b1;
        sda_low_o = 1'b0;
    end
    // Data moves mid-low phase, never at the falling edge itself
    task automatic clk_bit(input logic b, output logic s);
        scl_o = 1'b0;
        #8 sda_low_o = ~b;
        #8 scl_o = 1'b1;
        #8 s = sda_i;
        #8;
    endtask
    // Also serves as repeated start; long high time lets link leave reset
    task automatic start();
        scl_o = 1'b0;
        #8 sda_low_o = 1'b0;
        #8 scl_o = 1'b1;
        #16 sda_low_o = 1'b1;
        #48;
    endtask
    task automatic stop();
        scl_o = 1'b0;
        #8 sda_low_o = 1'b1;
        #8 scl_o = 1'b1;
        #16 sda_low_o = 1'b0;
        #48;
    endtask
    task automatic put(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(d[i], s);
        end
        clk_bit(1'b1, s);
        ack = (s === 1'b0);
    endtask
    task automatic get(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, d[i]);
        end
        // Ack low keeps the read going, a released line ends it
        clk_bit(last, s);
    endtask
    task automatic wr(input logic [7:0] a, r, d, output logic ok);
        logic k1, k2, k3;
        start();
        put(a, k1);
        put(r, k2);
        put(d, k3);
        stop();
        ok = k1 & k2 & k3;
    endtask
    task automatic rd(input logic [7:0] r, input int n,
                      output logic [31:0] q);
        logic       k;
        logic [7:0] b;
        q = 32'h0;
        start();
        put(8'hb4, k);
        put(r, k);
        start();
        put(8'hb5, k);
        for (int i = 0; i < n; i++) begin
            get(i == n - 1, b);
            q = {q[23:0], b};
        end
        stop();
    endtask
endmodule
`default_nettype wire

// File: tb/hcoc_top_tb_top.sv
// Purpose: Self-checking bench of the haptic calibration and fuse block
// Assumes: Short calibration and period units set through parameters
// Notes:   Register access only through the bus master model
`timescale 1ns/1ns
`default_nettype none
module hcoc_top_tb_top;
    localparam int CALN = 2000;
    typedef struct packed {
        logic [7:0] r, d, e;
        logic [3:0] f;
    } hcoc_row_t;
    // Flags: rotating open, resonant open, closed loop, freq tracking
    hcoc_row_t rows [7] = '{
        '{8'h1a, 8'h00, 8'h00, 4'h2},
        '{8'h1d, 8'h20, 8'h20, 4'h8},
        '{8'h1a, 8'h80, 8'h80, 4'h3},
        '{8'h1d, 8'h01, 8'h01, 4'h4},
        '{8'h00, 8'hff, 8'h00, 4'h4},
        '{8'h22, 8'h55, 8'h00, 4'h4},
        '{8'h20, 8'h05, 8'h05, 4'h4}};
    logic        core_clk = 1'b0;
    logic        rst_b    = 1'b0;
    logic        fuse_b   = 1'b0;
    logic        en       = 1'b0;
    logic        pwm      = 1'b0;
    logic [7:0]  bemf     = 8'h00;
    logic        scl, sda_low, sda_o, sda_oe, rmol, rsol, comm, closed;
    logic        ft, busy, ok;
    logic [6:0]  per;
    logic [7:0]  trim;
    logic [31:0] q;
    int          n_mismatch = 0;
    int          n_tests    = 0;
    int          pwm_n      = 0;
    int          c, p;
    wire  logic  sda_w;
    assign sda_w = (sda_oe ? sda_o : 1'b1) & ~sda_low;
    hcoc_host_model host (.scl_o(scl), .sda_low_o(sda_low), .sda_i(sda_w));
    hcoc_top #(.CAL_CYCLES(CALN), .OL_HALF_CYCLES(2)) uut (
        .core_clk_i(core_clk), .rst_b_i(rst_b), .fuse_blank_b_i(fuse_b),
        .scl_clk_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe),
        .en_i(en), .pwm_i(pwm), .bemf_level_i(bemf),
        .rotating_mass_openloop_o(rmol), .resonant_openloop_o(rsol),
        .drive_period_o(per), .commutate_o(comm), .closed_loop_o(closed),
        .level_trim_o(trim), .freq_track_o(ft), .cal_busy_o(busy));
    initial forever #4 core_clk = ~core_clk;
    initial forever begin
        repeat (4) @(negedge core_clk);
        pwm = ~pwm;
        if (pwm) pwm_n++;
    end
    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #500000;
        n_mismatch++;
        results();
    end
    task automatic chk(input logic [31:0] s, e);
        n_tests++;
        if (s !== e) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic w(input logic [7:0] r, d);
        host.wr(8'hb4, r, d, ok);
        chk(ok, 1);
    endtask
    task automatic rr(input logic [7:0] r, e);
        host.rd(r, 1, q);
        chk(q[7:0], e);
    endtask
    // Second toggle interval only: the first one may be cut short
    task automatic span();
        logic v;
        for (int k = 0; k < 2; k++) begin
            v = comm;
            c = 0;
            p = pwm_n;
            while (comm === v && c < 3000) begin
                @(negedge core_clk);
                #1;
                c++;
            end
        end
        p = pwm_n - p;
    endtask
    task automatic cal(input logic [7:0] b, e18, ed);
        bemf = b;
        w(8'h0c, 8'h01);
        chk(busy, 1);
        rr(8'h0c, 8'h01);
        c = 0;
        while (busy !== 1'b0 && c < 3 * CALN) begin
            @(negedge core_clk);
            c++;
        end
        rr(8'h0c, 8'h00);
        rr(8'h19, b);
        rr(8'h18, e18);
        chk(trim, e18);
        rr(8'h00, ed);
    endtask
    initial begin
        repeat (6) @(negedge core_clk);
        chk({busy, comm, rmol, rsol}, 0);
        rst_b = 1'b1;
        fuse_b = 1'b1;
        en = 1'b1;
        repeat (6) @(negedge core_clk);
        rr(8'h01, 8'h40);
        foreach (rows[i]) begin
            w(rows[i].r, rows[i].d);
            rr(rows[i].r, rows[i].e);
            chk({rmol, rsol, closed, ft}, rows[i].f);
        end
        host.wr(8'hb6, 8'h20, 8'h77, ok);
        chk(ok, 0);
        host.rd(8'h1d, 4, q);
        chk(q, 32'h01000005);
        chk(per, 7'h05);
        span();
        chk(c, 10);
        w(8'h01, 8'h03);
        span();
        chk(p, 64);
        w(8'h01, 8'h07);
        w(8'h16, 8'h40);
        w(8'h17, 8'h60);
        w(8'h1b, 8'h05);
        cal(8'h33, 8'h3b, 8'h00);
        w(8'h1a, 8'h00);
        cal(8'h00, 8'h40, 8'h08);
        en = 1'b0;
        rr(8'h18, 8'h40);
        w(8'h1e, 8'h01);
        host.rd(8'h1e, 1, q);
        chk(q[2], 1);
        w(8'h16, 8'h11);
        w(8'h01, 8'h80);
        rr(8'h16, 8'h40);
        rr(8'h17, 8'h60);
        rr(8'h20, 8'h00);
        w(8'h16, 8'h11);
        w(8'h1e, 8'h01);
        @(negedge core_clk);
        rst_b = 1'b0;
        repeat (6) @(negedge core_clk);
        rst_b = 1'b1;
        repeat (6) @(negedge core_clk);
        rr(8'h16, 8'h40);
        host.rd(8'h1e, 1, q);
        chk(q[2], 1);
        results();
    end
endmodule
`default_nettype wire

// File: verilog/hcoc_cfg.svh
// Purpose: Register map, field positions and timing figures of the
//          haptic calibration and fuse-store control block
// Assumes: 125 MHz core clock, one 8-bit register per bus address
// Notes:   Included by the package and the top module
`ifndef HCOC_CFG_SVH
`define HCOC_CFG_SVH

`define HC_DEV_ADDR    7'h5a
`define HC_R_DIAG      8'h00
`define HC_R_MODE      8'h01
`define HC_R_GO        8'h0c
`define HC_R_RATED     8'h16
`define HC_R_CLAMP     8'h17
`define HC_R_COMP      8'h18
`define HC_R_BEMF      8'h19
`define HC_R_FBCTL     8'h1a
`define HC_R_CTL2      8'h1b
`define HC_R_CTL3      8'h1d
`define HC_R_OTP       8'h1e
`define HC_R_OLP       8'h20
`define HC_NREG        34
`define HC_OTP_N       5

`define HC_B_TYPE      7
`define HC_B_RMOL      5
`define HC_B_RSOL      0
`define HC_B_PWMAN     1
`define HC_B_RST       7
`define HC_B_STBY      6
`define HC_B_GO        0
`define HC_B_OTPPG     0
`define HC_B_OTPST     2
`define HC_B_DIAG      3

`define HC_MODE_RST    8'h40
`define HC_MODE_CAL    3'h7
`define HC_MODE_PWM    3'h3
`define HC_PWM_HALF    7'h3f
`define HC_BIT_ACK     4'h8
`define HC_BIT_END     4'h9
`define HC_BIT_ARM     4'hf

`define HC_CLK_NS      8
`define HC_CAL_NS      1000000
`define HC_OL_UNIT_NS  98460

`endif

// File: verilog/hcoc_pkg.sv
// Purpose: Types of the haptic calibration and fuse-store control block
// Assumes: Constants come from hcoc_cfg.svh
// Notes:   Link state lives on the bus clock, core state on core_clk_i
`default_nettype none
`include "hcoc_cfg.svh"
package hcoc_pkg;
    typedef enum logic [2:0] {
        LK_ADDR, LK_REG, LK_WDAT, LK_RDAT, LK_IDLE
    } hcoc_link_st_t;

    typedef struct packed {
        logic       sda_p;
        logic [7:0] sh;
    } hcoc_rx_t;

    typedef struct packed {
        hcoc_link_st_t st;
        logic [3:0]    c;
        logic          rw;
        logic [7:0]    ptr;
        logic          oe;
        logic          sdo;
        logic [7:0]    tx;
        logic          wt;
        logic [7:0]    wa;
        logic [7:0]    wd;
        logic          rt;
    } hcoc_link_t;

    typedef struct packed {
        logic                          sc1, sc2, sd1, sd2, sd3;
        logic                          en1, en2, pw1, pw2, pw3;
        logic                          rs1, rs2, rs3, ws1, ws2, ws3;
        logic                          lclr;
        logic                          reload;
        logic [`HC_NREG-1:0][7:0]      regs;
        logic [7:0]                    rdata;
        logic [`HC_OTP_N-1:0][7:0]     otp;
        logic                          otp_done;
        logic                          cal_run;
        logic [23:0]                   cal_cnt;
        logic [6:0]                    pcnt;
        logic [23:0]                   tcnt;
        logic                          comm;
        logic                          rmol, rsol, closed, ftrk;
        logic [6:0]                    period;
        logic [7:0]                    level;
    } hcoc_core_t;
endpackage
`default_nettype wire

// File: verilog/hcoc_top.sv
// Purpose: Bus slave, calibration sequencer and fuse store of a haptic
//          actuator driver
// Assumes: scl_clk_i clocks the link; core_clk_i at 125 MHz
// Notes:   Link logic is reset by the core while the bus is idle
// Function
// - Read opens with write-direction address, register
// - Repeated start, read address, device returns data
// - Multi-byte read: master acks all but last
// - Read data advances through following registers
// - Answer only bus address 0x5A
// - Type bit 0 plus flag: rotating open loop
// - Type bit 1 plus flag: resonant open loop
// - PWM resonant open loop: commutation PWM/128
// - Otherwise period field sets resonant drive
// - Closed loop trims level, resonant also frequency
// - Rotating type ignores resonant-only calibration inputs
// - Start bit launches calibration, self-clears, stores results
// - Diagnostic bit reports calibration fault
// - Registers kept in standby or enable low
// - Fuse store covers 0x16-0x1A, programs once
// - Writing 0x01 to 0x1E programs store
// - Programmed status bit reads 1 until fuse_blank_b_i goes low
// - Reset or soft reset reloads stored values
`timescale 1ns/1ns
`default_nettype none
`include "hcoc_cfg.svh"
module hcoc_top #(
    parameter int CAL_CYCLES     = `HC_CAL_NS / `HC_CLK_NS,
    parameter int OL_HALF_CYCLES = `HC_OL_UNIT_NS / `HC_CLK_NS
) (
    input  wire logic       core_clk_i,
    input  wire logic       rst_b_i,
    input  wire logic       fuse_blank_b_i,
    input  wire logic       scl_clk_i,
    input  wire logic       sda_i,
    output var  logic       sda_o,
    output var  logic       sda_oe_o,
    input  wire logic       en_i,
    input  wire logic       pwm_i,
    input  wire logic [7:0] bemf_level_i,
    output var  logic       rotating_mass_openloop_o,
    output var  logic       resonant_openloop_o,
    output var  logic [6:0] drive_period_o,
    output var  logic       commutate_o,
    output var  logic       closed_loop_o,
    output var  logic [7:0] level_trim_o,
    output var  logic       freq_track_o,
    output var  logic       cal_busy_o
);
    hcoc_pkg::hcoc_core_t q, d;
    hcoc_pkg::hcoc_rx_t   p;
    hcoc_pkg::hcoc_link_t n, nd;
    logic [3:0]  c1;
    logic [23:0] half_tgt;
    logic        rmol_c, rsol_c, pwm_act;

    function automatic logic [7:0] rd_reg(hcoc_pkg::hcoc_core_t s,
                                          logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (a == `HC_R_GO) begin
            v = s.regs[`HC_R_GO];
            v[`HC_B_GO] = s.regs[`HC_R_GO][`HC_B_GO] | s.cal_run;
        end else if (a == `HC_R_OTP) begin
            v = s.regs[`HC_R_OTP];
            v[`HC_B_OTPST] = s.otp_done;
        end else if (a < 8'(`HC_NREG)) begin
            v = s.regs[a[5:0]];
        end
        return v;
    endfunction

    // Bus-clock side: bits are taken on the rising edge
    always_ff @(posedge scl_clk_i or posedge q.lclr) begin
        if (q.lclr) begin
            p <= '0;
        end else begin
            p.sda_p <= sda_i;
            p.sh    <= {p.sh[6:0], sda_i};
        end
    end

    // Bus-clock side: SDA only moves after the falling edge
    always_comb begin
        nd = n;
        c1 = n.c + 4'h1;
        if (n.c == `HC_BIT_ARM) begin
            nd.c = 4'h0;
        end else if (p.sda_p && !sda_i) begin
            nd.st = hcoc_pkg::LK_ADDR;
            nd.c  = 4'h0;
            nd.oe = 1'b0;
        end else begin
            nd.c = (c1 == `HC_BIT_END) ? 4'h0 : c1;
            case (n.st)
                hcoc_pkg::LK_ADDR: begin
                    if (c1 == `HC_BIT_ACK) begin
                        if (p.sh[7:1] == `HC_DEV_ADDR) begin
                            nd.oe = 1'b1;
                            nd.rw = p.sh[0];
                        end else begin
                            nd.st = hcoc_pkg::LK_IDLE;
                        end
                    end else if (c1 == `HC_BIT_END) begin
                        nd.oe = 1'b0;
                        if (n.rw) begin
                            nd.st  = hcoc_pkg::LK_RDAT;
                            nd.tx  = q.rdata;
                            nd.oe  = !q.rdata[7];
                            nd.ptr = n.ptr + 8'h01;
                            nd.rt  = !n.rt;
                        end else begin
                            nd.st = hcoc_pkg::LK_REG;
                        end
                    end
                end
                hcoc_pkg::LK_REG: begin
                    if (c1 == `HC_BIT_ACK) begin
                        nd.oe  = 1'b1;
                        nd.ptr = p.sh;
                        nd.rt  = !n.rt;
                    end else if (c1 == `HC_BIT_END) begin
                        nd.oe = 1'b0;
                        nd.st = hcoc_pkg::LK_WDAT;
                    end
                end
                hcoc_pkg::LK_WDAT: begin
                    if (c1 == `HC_BIT_ACK) begin
                        nd.oe  = 1'b1;
                        nd.wa  = n.ptr;
                        nd.wd  = p.sh;
                        nd.wt  = !n.wt;
                        nd.ptr = n.ptr + 8'h01;
                        nd.rt  = !n.rt;
                    end else if (c1 == `HC_BIT_END) begin
                        nd.oe = 1'b0;
                    end
                end
                hcoc_pkg::LK_RDAT: begin
                    if (c1 < `HC_BIT_ACK) begin
                        nd.oe = !n.tx[6];
                        nd.tx = {n.tx[6:0], 1'b0};
                    end else if (c1 == `HC_BIT_ACK) begin
                        nd.oe = 1'b0;
                    end else if (!p.sda_p) begin
                        nd.tx  = q.rdata;
                        nd.oe  = !q.rdata[7];
                        nd.ptr = n.ptr + 8'h01;
                        nd.rt  = !n.rt;
                    end else begin
                        nd.st = hcoc_pkg::LK_IDLE;
                    end
                end
                default: begin
                    nd.oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(negedge scl_clk_i or posedge q.lclr) begin
        if (q.lclr) begin
            n   <= '0;
            n.c <= `HC_BIT_ARM;
        end else begin
            n <= nd;
        end
    end

    // Core side
    assign rmol_c  = !q.regs[`HC_R_FBCTL][`HC_B_TYPE]
                   && q.regs[`HC_R_CTL3][`HC_B_RMOL];
    assign rsol_c  = q.regs[`HC_R_FBCTL][`HC_B_TYPE]
                   && q.regs[`HC_R_CTL3][`HC_B_RSOL];
    assign pwm_act = (q.regs[`HC_R_MODE][2:0] == `HC_MODE_PWM)
                   && !q.regs[`HC_R_CTL3][`HC_B_PWMAN];
    assign half_tgt = 24'(q.regs[`HC_R_OLP][6:0] * OL_HALF_CYCLES);

    always_comb begin
        d = q;
        d.sc1 = scl_clk_i;
        d.sc2 = q.sc1;
        d.sd1 = sda_i;
        d.sd2 = q.sd1;
        d.sd3 = q.sd2;
        d.en1 = en_i;
        d.en2 = q.en1;
        d.pw1 = pwm_i;
        d.pw2 = q.pw1;
        d.pw3 = q.pw2;
        d.rs1 = n.rt;
        d.rs2 = q.rs1;
        d.rs3 = q.rs2;
        d.ws1 = n.wt;
        d.ws2 = q.ws1;
        d.ws3 = q.ws2;
        d.reload = 1'b0;
        // Hold the link in reset between stop and start
        if (q.sc2 && !q.sd3 && q.sd2) begin
            d.lclr = 1'b1;
        end else if (q.sc2 && q.sd3 && !q.sd2) begin
            d.lclr = 1'b0;
        end
        if (q.rs2 != q.rs3 && !q.lclr) begin
            d.rdata = rd_reg(q, n.ptr);
        end
        if (q.reload) begin
            d.regs = '0;
            d.regs[`HC_R_MODE] = `HC_MODE_RST;
            d.cal_run = 1'b0;
            if (q.otp_done) begin
                for (int i = 0; i < `HC_OTP_N; i++) begin
                    d.regs[`HC_R_RATED + i] = q.otp[i];
                end
            end
        end
        if (q.cal_run) begin
            if (!q.en2 || q.cal_cnt == 24'(CAL_CYCLES - 1)) begin
                d.cal_run = 1'b0;
                d.regs[`HC_R_GO][`HC_B_GO] = 1'b0;
                d.regs[`HC_R_DIAG][`HC_B_DIAG] = !q.en2
                    || (bemf_level_i == 8'h00);
                if (q.en2) begin
                    d.regs[`HC_R_BEMF] = bemf_level_i;
                    // Drive-time trim only makes sense for resonant parts
                    d.regs[`HC_R_COMP] = q.regs[`HC_R_FBCTL][`HC_B_TYPE]
                        ? q.regs[`HC_R_RATED]
                          - {3'h0, q.regs[`HC_R_CTL2][4:0]}
                        : q.regs[`HC_R_RATED];
                end
            end else begin
                d.cal_cnt = q.cal_cnt + 24'h1;
            end
        end
        // Software write lands after the hardware update: software wins, except at 0x00 where the old value stays
        if (q.ws2 != q.ws3 && !q.lclr && !q.reload) begin
            if (n.wa == `HC_R_DIAG) begin
                d.regs[`HC_R_DIAG] = q.regs[`HC_R_DIAG];
            end else if (n.wa == `HC_R_MODE) begin
                d.regs[`HC_R_MODE] = {1'b0, n.wd[6:0]};
                d.reload = n.wd[`HC_B_RST];
            end else if (n.wa == `HC_R_GO) begin
                d.regs[`HC_R_GO] = n.wd;
                if (n.wd[`HC_B_GO] && q.en2
                    && q.regs[`HC_R_MODE][2:0] == `HC_MODE_CAL
                    && !q.regs[`HC_R_MODE][`HC_B_STBY]) begin
                    d.cal_run = 1'b1;
                    d.cal_cnt = 24'h0;
                end
            end else if (n.wa == `HC_R_OTP) begin
                d.regs[`HC_R_OTP] = n.wd;
                if (n.wd[`HC_B_OTPPG] && !q.otp_done) begin
                    for (int i = 0; i < `HC_OTP_N; i++) begin
                        d.otp[i] = q.regs[`HC_R_RATED + i];
                    end
                    d.otp_done = 1'b1;
                end
            end else if (n.wa < 8'(`HC_NREG)) begin
                d.regs[n.wa[5:0]] = n.wd;
            end
        end
        if (!fuse_blank_b_i) begin
            d.otp = '0;
            d.otp_done = 1'b0;
        end
        d.rmol   = rmol_c;
        d.rsol   = rsol_c;
        d.period = q.regs[`HC_R_OLP][6:0];
        d.closed = !(rmol_c || rsol_c);
        d.ftrk   = !(rmol_c || rsol_c) && q.regs[`HC_R_FBCTL][`HC_B_TYPE];
        d.level  = q.regs[`HC_R_COMP];
        if (rsol_c && pwm_act) begin
            d.tcnt = 24'h0;
            if (q.pw2 && !q.pw3) begin
                if (q.pcnt == `HC_PWM_HALF) begin
                    d.pcnt = 7'h0;
                    d.comm = !q.comm;
                end else begin
                    d.pcnt = q.pcnt + 7'h1;
                end
            end
        end else if (rsol_c && half_tgt != 24'h0) begin
            d.pcnt = 7'h0;
            if (q.tcnt >= half_tgt - 24'h1) begin
                d.tcnt = 24'h0;
                d.comm = !q.comm;
            end else begin
                d.tcnt = q.tcnt + 24'h1;
            end
        end else begin
            d.pcnt = 7'h0;
            d.tcnt = 24'h0;
            d.comm = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            q          <= '0;
            q.lclr     <= 1'b1;
            q.reload   <= 1'b1;
            q.otp      <= fuse_blank_b_i ? q.otp : '0;
            q.otp_done <= fuse_blank_b_i ? q.otp_done : 1'b0;
        end else begin
            q <= d;
        end
    end

    assign sda_o                    = n.sdo;
    assign sda_oe_o                 = n.oe;
    assign rotating_mass_openloop_o = q.rmol;
    assign resonant_openloop_o      = q.rsol;
    assign drive_period_o           = q.period;
    assign commutate_o              = q.comm;
    assign closed_loop_o            = q.closed;
    assign level_trim_o             = q.level;
    assign freq_track_o             = q.ftrk;
    assign cal_busy_o               = q.cal_run;

    go_busy_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        q.cal_run |-> rd_reg(q, `HC_R_GO) == (q.regs[`HC_R_GO] | 8'h01))
        else $error("start bit low while calibrating");
    cal_clear_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        $fell(q.cal_run) |-> !q.regs[`HC_R_GO][`HC_B_GO] && !cal_busy_o)
        else $error("start bit not cleared at end");
    cal_run_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        $rose(q.cal_run) && q.en2 |-> q.cal_run [*4])
        else $error("calibration ended too early");
    diag_fault_a: assert property (@(posedge core_clk_i)
        disable iff (!rst_b_i)
        $fell(q.cal_run) && !$past(q.reload) && $past(bemf_level_i) == 8'h00
        |-> q.regs[`HC_R_DIAG][`HC_B_DIAG])
        else $error("fault not reported");
    rot_open_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        ##1 rotating_mass_openloop_o == $past(rmol_c))
        else $error("rotating open loop select wrong");
    res_open_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        ##1 resonant_openloop_o == $past(q.regs[`HC_R_FBCTL][`HC_B_TYPE]
            && q.regs[`HC_R_CTL3][`HC_B_RSOL]))
        else $error("resonant open loop select wrong");
    period_out_a: assert property (@(posedge core_clk_i)
        disable iff (!rst_b_i)
        ##1 drive_period_o == $past(q.regs[`HC_R_OLP][6:0]))
        else $error("period field not applied");
    fuse_keep_a: assert property (@(posedge core_clk_i)
        disable iff (!fuse_blank_b_i)
        q.otp_done |=> q.otp_done && $stable(q.otp))
        else $error("fuse store changed after programming");
    fuse_stat_a: assert property (@(posedge core_clk_i)
        disable iff (!rst_b_i)
        q.otp_done |-> rd_reg(q, `HC_R_OTP) == (q.regs[`HC_R_OTP] | 8'h04))
        else $error("programmed status not read as one");
    fuse_load_a: assert property (@(posedge core_clk_i)
        disable iff (!rst_b_i)
        q.reload && q.otp_done |=> q.regs[`HC_R_RATED] == q.otp[0]
            && q.regs[`HC_R_FBCTL] == q.otp[4])
        else $error("stored values not reloaded");

    cal_done_c: cover property (@(posedge core_clk_i) disable iff (!rst_b_i)
        $fell(q.cal_run) && !q.regs[`HC_R_DIAG][`HC_B_DIAG]);
    fuse_prog_c: cover property (@(posedge core_clk_i) disable iff (!rst_b_i)
        $rose(q.otp_done));
    comm_pwm_c: cover property (@(posedge core_clk_i) disable iff (!rst_b_i)
        pwm_act && rsol_c && $changed(q.comm));
    bus_read_c: cover property (@(posedge core_clk_i) disable iff (!rst_b_i)
        q.rs2 != q.rs3 && !q.lclr);
endmodule
`default_nettype wire
